// *** src/ocu_top.sv ***
`timescale 1ns/1ps
// Two-channel output compare unit of a 16-bit timer.
module ocu_top #(
	parameter int NCH = ocu_pkg::NCH
) (
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire logic             tick,
	input  wire logic [15:0]      timer_count,
	input  wire logic             up_count,
	input  wire logic             at_top,
	input  wire logic             at_bottom,
	input  wire logic             count_write,
	input  wire logic [3:0]       waveform_select,
	input  wire logic [NCH-1:0]   wr_high,
	input  wire logic [NCH-1:0]   wr_low,
	input  wire logic [7:0]       wr_data,
	input  wire logic [NCH-1:0]   rd_sel,
	input  wire logic [NCH-1:0]   flag_clear,
	input  wire logic [NCH-1:0]   irq_ack,
	input  wire logic [NCH-1:0]   force_match_strobe,
	input  wire logic [NCH-1:0]   compare_irq_enable_wr,
	input  wire logic [NCH-1:0]   compare_irq_enable_in,
	input  wire logic [NCH*2-1:0] output_action_wr_data,
	input  wire logic [NCH-1:0]   output_action_wr,
	input  wire logic [NCH-1:0]   port_value,
	input  wire logic [NCH-1:0]   pin_direction_bit,
	output logic      [15:0]      rd_word,
	output logic      [NCH-1:0]   compare_match_flag,
	output logic      [NCH-1:0]   compare_irq,
	output logic      [NCH-1:0]   wave_output,
	output logic      [NCH-1:0]   pin_out,
	output logic      [NCH-1:0]   pin_oe,
	output logic      [15:0]      top_from_a
);
	typedef struct packed {
		logic [7:0]       latch;
		logic             blk;
		logic [NCH-1:0]   ien;
		logic [NCH*2-1:0] oas;
		logic [15:0]      rd;
		logic [NCH-1:0]   irq;
		logic [NCH-1:0]   pout;
		logic [NCH-1:0]   poe;
		logic [15:0]      topa;
	} ocu_top_s;
	ocu_top_s        st, next_st;
	logic            pwm_mode;
	logic            nonpwm_mode;
	logic [15:0]     cv   [NCH];
	logic [15:0]     view [NCH];
	logic [NCH-1:0]  flg;
	logic [NCH-1:0]  wav;

	////////////////////////////////////////////////////////////////////
	// Mode decode: twelve PWM codes, the rest non-PWM
	function automatic logic is_pwm(input logic [3:0] w);
		return !(w == ocu_pkg::WGM_NORMAL || w == ocu_pkg::WGM_CTC_A ||
			w == ocu_pkg::WGM_CTC_CAP || w == ocu_pkg::WGM_RSVD);
	endfunction : is_pwm

	assign pwm_mode    = is_pwm(waveform_select);
	assign nonpwm_mode = !is_pwm(waveform_select);

	////////////////////////////////////////////////////////////////////
	// Channels
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			ocu_channel u_ch (
				.ref_clk              (ref_clk),
				.resetn               (resetn),
				.tick                 (tick),
				.pwm_mode             (pwm_mode),
				.nonpwm_mode          (nonpwm_mode),
				.at_top               (at_top),
				.at_bottom            (at_bottom),
				.timer_count          (timer_count),
				.block_match          (st.blk),
				.wr_low               (wr_low[i]),
				.wr_word              ({st.latch, wr_data}),
				.flag_clr             (flag_clear[i]),
				.irq_ack              (irq_ack[i]),
				.force_match_strobe   (force_match_strobe[i]),
				.output_action_select (st.oas[2*i +: 2]),
				.up_count             (up_count),
				.compare_value        (cv[i]),
				.cpu_view             (view[i]),
				.compare_match_flag   (flg[i]),
				.wave_output          (wav[i]),
				.match                ()
			);
		end
	endgenerate

	assign compare_match_flag = flg;
	assign wave_output        = wav;
	assign rd_word            = st.rd;
	assign compare_irq        = st.irq;
	assign pin_out            = st.pout;
	assign pin_oe             = st.poe;
	assign top_from_a         = st.topa;

	////////////////////////////////////////////////////////////////////
	// Shared latch, blocking, controls, pin override
	always_comb begin
		next_st = st;
		if (|wr_high) begin
			next_st.latch = wr_data;
		end
		// Block holds until the next timer tick, even if the clock is stopped
		if (count_write) begin
			next_st.blk = 1'b1;
		end else if (tick) begin
			next_st.blk = 1'b0;
		end
		for (int i = 0; i < NCH; i++) begin
			if (compare_irq_enable_wr[i]) begin
				next_st.ien[i] = compare_irq_enable_in[i];
			end
			if (output_action_wr[i]) begin
				next_st.oas[2*i +: 2] = output_action_wr_data[2*i +: 2];
			end
			next_st.irq[i]  = flg[i] && st.ien[i];
			next_st.pout[i] = (st.oas[2*i +: 2] != ocu_pkg::ACT_NONE) ?
				wav[i] : port_value[i];
			next_st.poe[i]  = pin_direction_bit[i];
		end
		next_st.rd = 16'h0000;
		for (int i = 0; i < NCH; i++) begin
			if (rd_sel[i]) begin
				next_st.rd = view[i];
			end
		end
		next_st.topa = cv[0];
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : ocu_top

// *** inc/ocu_pkg.sv ***
// Operation
// - Each channel compares the 16-bit count with its value every cycle.
// - A match sets the channel flag one timer clock later.
// - Flag with enable set raises interrupt; flag clears when interrupt serviced.
// - Writing one to the flag bit clears it; zero leaves it.
// - Channel A compare value can serve as counter TOP.
// - Compare value buffered in the twelve PWM modes, direct in normal and clear-on-match.
// - Buffered value moves to active register only at TOP or BOTTOM.
// - CPU writes reach the buffer when buffering, else the active register.
// - Only CPU writes change the value; high byte reads return register directly.
// - High byte write loads latch; low byte write commits both bytes together.
// - Force strobe in non-PWM modes updates output like an up-counting match, no flag.
// - Count write suppresses matches in the following timer clock cycle.
// - Waveform output bit keeps its value across mode changes.
// - Output action select is unbuffered and applies at the next match.
// - Reset clears every waveform output bit to zero.
// - Nonzero action select makes waveform output override the port value.
// - Action select zero leaves the waveform output unchanged on match.
// - Action select does not affect input capture.
// - Waveform select zero is normal mode, non-PWM, counting up.
// - Waveform select 4 and 12 are clear-on-match, TOP from A or capture.
package ocu_pkg;
	localparam int          CNT_W       = 16;
	localparam int          NCH         = 2;
	localparam logic [15:0] VALUE_RST   = 16'h0000;
	localparam logic [7:0]  LATCH_RST   = 8'h00;
	localparam logic [3:0]  WGM_NORMAL  = 4'h0;
	localparam logic [3:0]  WGM_CTC_A   = 4'h4;
	localparam logic [3:0]  WGM_CTC_CAP = 4'hC;
	localparam logic [3:0]  WGM_RSVD    = 4'hD;
	localparam logic [1:0]  ACT_NONE    = 2'h0;
	localparam logic [1:0]  ACT_TOGGLE  = 2'h1;
	localparam logic [1:0]  ACT_CLEAR   = 2'h2;
	localparam logic [1:0]  ACT_SET     = 2'h3;
endpackage : ocu_pkg

// *** src/ocu_channel.sv ***
`timescale 1ns/1ps
// One compare channel: value store, buffer, flag, waveform bit.
module ocu_channel (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        tick,
	input  wire logic        pwm_mode,
	input  wire logic        nonpwm_mode,
	input  wire logic        at_top,
	input  wire logic        at_bottom,
	input  wire logic [15:0] timer_count,
	input  wire logic        block_match,
	input  wire logic        wr_low,
	input  wire logic [15:0] wr_word,
	input  wire logic        flag_clr,
	input  wire logic        irq_ack,
	input  wire logic        force_match_strobe,
	input  wire logic [1:0]  output_action_select,
	input  wire logic        up_count,
	output logic      [15:0] compare_value,
	output logic      [15:0] cpu_view,
	output logic             compare_match_flag,
	output logic             wave_output,
	output logic             match
);
	typedef struct packed {
		logic [15:0] active;
		logic [15:0] buffer;
		logic        flag;
		logic        wave;
		logic        pend;
	} ocu_ch_s;
	ocu_ch_s st, next_st;
	logic    hit;
	logic    upd;

	////////////////////////////////////////////////////////////////////
	// Match and output action
	assign hit           = (timer_count == st.active) && !block_match;
	assign compare_value = st.active;
	assign cpu_view      = pwm_mode ? st.buffer : st.active;
	assign compare_match_flag = st.flag;
	assign wave_output   = st.wave;
	assign match         = hit;

	function automatic logic act(input logic cur, input logic [1:0] sel, input logic dir);
		logic r;
		r = cur;
		case (sel)
			ocu_pkg::ACT_NONE:   r = cur;
			ocu_pkg::ACT_TOGGLE: r = ~cur;
			ocu_pkg::ACT_CLEAR:  r = dir ? 1'b0 : 1'b1;
			ocu_pkg::ACT_SET:    r = dir ? 1'b1 : 1'b0;
			default:             r = cur;
		endcase
		return r;
	endfunction : act

	always_comb begin
		next_st = st;
		upd     = 1'b0;
		if (wr_low) begin
			if (pwm_mode) begin
				next_st.buffer = wr_word;
			end else begin
				next_st.active = wr_word;
				next_st.buffer = wr_word;
			end
		end
		if (tick) begin
			// Flag lands one timer clock after the match
			next_st.pend = hit;
			if (st.pend) begin
				upd = 1'b1;
			end
			if (hit) begin
				next_st.wave = act(st.wave, output_action_select, up_count);
			end
			if (pwm_mode && (at_top || at_bottom)) begin
				next_st.active = st.buffer;
			end
		end
		if (nonpwm_mode && force_match_strobe) begin
			next_st.wave = act(st.wave, output_action_select, 1'b1);
		end
		// Set beats clear when both land together
		if (flag_clr || irq_ack) begin
			next_st.flag = 1'b0;
		end
		if (upd) begin
			next_st.flag = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '{active: ocu_pkg::VALUE_RST, buffer: ocu_pkg::VALUE_RST,
				flag: 1'b0, wave: 1'b0, pend: 1'b0};
		end else begin
			st <= next_st;
		end
	end
endmodule : ocu_channel

// *** test/ocu_checker.sv ***
`timescale 1ns/1ps
module ocu_checker #(parameter int NCH = 2) (
	input wire logic		ref_clk,
	input wire logic		resetn,
	input wire logic		tick,
	input wire logic [3:0]		waveform_select,
	input wire logic [NCH-1:0]	wr_high,
	input wire logic [NCH-1:0]	wr_low,
	input wire logic [7:0]		wr_data,
	input wire logic [NCH-1:0]	flag_clear,
	input wire logic [NCH-1:0]	irq_ack,
	input wire logic [NCH-1:0]	force_match_strobe,
	input wire logic [NCH-1:0]	compare_match_flag,
	input wire logic [NCH-1:0]	compare_irq,
	input wire logic [NCH-1:0]	wave_output,
	input wire logic [15:0]		top_from_a
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Normal mode only: in PWM the pair lands in the buffer
	sequence s_pair; wr_high[0] ##1 wr_low[0] && waveform_select == 4'h0; endsequence
	a_word_commit: assert property (
		s_pair |-> ##2 top_from_a == {$past(wr_data, 3), $past(wr_data, 2)}) else $error("commit");
	a_reset_zero: assert property (
		$rose(resetn) |-> compare_match_flag == 2'h0 && wave_output == 2'h0) else $error("reset");
	a_irq_follow: assert property (compare_irq[0] |-> $past(compare_match_flag[0]))
		else $error("irq");
	a_flag_drop: assert property (
		$fell(compare_match_flag[0]) |-> $past(flag_clear[0] || irq_ack[0])) else $error("drop");
	a_flag_tick: assert property ($rose(compare_match_flag[0]) |-> $past(tick))
		else $error("flag");
	a_flag_hold: assert property (
		compare_match_flag[0] && !flag_clear[0] && !irq_ack[0] |=> compare_match_flag[0])
		else $error("hold");
	a_wave_cause: assert property (
		$changed(wave_output[0]) |-> $past(tick || force_match_strobe[0])) else $error("wave");
	a_top_stable: assert property (
		$changed(top_from_a) |-> $past(wr_low[0], 2) || $past(tick, 2)) else $error("top");
endmodule : ocu_checker

bind ocu_top ocu_checker #(.NCH(NCH)) u_ocu_checker (.ref_clk, .resetn, .tick,
	.waveform_select, .wr_high, .wr_low, .wr_data, .flag_clear, .irq_ack, .force_match_strobe,
	.compare_match_flag, .compare_irq, .wave_output, .top_from_a);

// *** test/ocu_cpu_model.sv ***
`timescale 1ns/1ps
// Channel A writer; bus is scrambled when idle
module ocu_cpu_model (
	input wire logic	ref_clk,
	input wire logic	req,
	input wire logic [15:0]	val,
	output logic [1:0]	wr_high = 2'h0,
	output logic [1:0]	wr_low = 2'h0,
	output logic [7:0]	wr_data = 8'h00
);
	always_ff @(posedge ref_clk) begin
		wr_high <= {1'b0, req && !wr_high[0]};
		wr_low <= {1'b0, wr_high[0]};
		wr_data <= wr_high[0] ? val[7:0] : req ? val[15:8] : ~wr_data;
	end
endmodule : ocu_cpu_model

// *** test/output_compare_unit_16bit_bench.sv ***
`timescale 1ns/1ps
module output_compare_unit_16bit_bench;
	logic ref_clk = 1'b0, resetn = 1'b0, tick = 1'b0, at_top = 1'b0, count_write = 1'b0;
	logic req = 1'b0;
	logic [1:0] compare_irq_enable_in = 2'h1, port_value = 2'h1, pin_direction_bit = 2'h0;
	logic [15:0] timer_count = 16'h0000, val = 16'h0000, v, rd_word, top_from_a;
	logic [3:0] waveform_select = 4'h0, output_action_wr_data = 4'h0;
	logic [1:0] rd_sel = 2'h0, flag_clear = 2'h0, irq_ack = 2'h0, force_match_strobe = 2'h0;
	logic [1:0] output_action_wr = 2'h0, compare_irq_enable_wr = 2'h0, wr_high, wr_low;
	logic [1:0] compare_match_flag, compare_irq, wave_output, pin_out, pin_oe;
	logic [7:0] wr_data;
	logic [31:0] rs = 32'h1ca86730;
	int errors = 0, num_checks = 0;
	ocu_top #(.NCH(2)) u_ocu_top (.ref_clk, .resetn, .tick, .timer_count, .up_count(1'b1),
		.at_top, .at_bottom(1'b0), .count_write, .waveform_select, .wr_high, .wr_low, .wr_data,
		.rd_sel, .flag_clear, .irq_ack, .force_match_strobe, .compare_irq_enable_wr,
		.compare_irq_enable_in, .output_action_wr_data, .output_action_wr,
		.port_value, .pin_direction_bit, .rd_word, .compare_match_flag,
		.compare_irq, .wave_output, .pin_out, .pin_oe, .top_from_a);
	ocu_cpu_model u_ocu_cpu_model (.ref_clk, .req, .val, .wr_high, .wr_low, .wr_data);
	initial forever #2.5 ref_clk = ~ref_clk;
	////////////////////////////////
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	// Counting up: 2 clears, 3 sets
	function automatic logic nw(logic w, logic [1:0] a);
		return a == 2'h0 ? w : a == 2'h1 ? ~w : a == 2'h3;
	endfunction : nw
	task automatic chk(logic [15:0] g, e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: saw %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude
	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : cyc
	// Two ticks: count c then c+1, so a flag shows
	task automatic mt(logic [15:0] c);
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			timer_count <= c + 16'(i);
			tick <= 1'b1;
			@(posedge ref_clk);
			tick <= 1'b0;
		end
		cyc(2);
	endtask : mt
	task automatic pul(logic [1:0] f, a, c, o, logic w, logic [3:0] d);
		@(posedge ref_clk);
		{force_match_strobe, irq_ack, flag_clear, output_action_wr} <= {f, a, c, o};
		{compare_irq_enable_wr, count_write, output_action_wr_data, rd_sel} <= {o, w, d, 2'h1};
		@(posedge ref_clk);
		{force_match_strobe, irq_ack, flag_clear, output_action_wr} <= 8'h00;
		{compare_irq_enable_wr, count_write} <= 3'h0;
		cyc(1);
	endtask : pul
	task automatic wr(logic [15:0] x);
		@(posedge ref_clk);
		req <= 1'b1;
		val <= x;
		@(posedge ref_clk);
		req <= 1'b0;
		for (int i = 0; i < 8 && wr_low[0] !== 1'b1; i++) @(negedge ref_clk);
		if (wr_low[0] !== 1'b1) begin
			errors++;
			conclude();
		end
		cyc(2);
	endtask : wr
	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		cyc(1);
		chk(16'({compare_match_flag, wave_output}), 16'h0000);
		chk(rd_word, 16'h0000);
		rs = xs(rs);
		v = rs[15:0] & 16'h7FFF | 16'h0001;
		pul(2'h0, 2'h0, 2'h0, 2'h3, 1'b0, 4'hD);
		wr(v);
		chk(rd_word, v);
		chk(top_from_a, v);
		mt(v);
		chk(16'({compare_irq, compare_match_flag, wave_output}), 16'({5'h0A, nw(1'b0, 2'h1)}));
		pul(2'h0, 2'h1, 2'h0, 2'h0, 1'b0, 4'hD);
		chk(16'(compare_match_flag), 16'h0000);
		pul(2'h3, 2'h0, 2'h0, 2'h0, 1'b0, 4'hD);
		chk(16'({compare_match_flag, wave_output}), 16'({nw(1'b0, 2'h3), nw(1'b1, 2'h1)}));
		// Pin made an output only once the wave bit is set up
		@(posedge ref_clk);
		pin_direction_bit <= 2'h3;
		$display("test match and force done");
		// Count written away from TOP and BOTTOM
		pul(2'h0, 2'h0, 2'h0, 2'h0, 1'b1, 4'hD);
		mt(v);
		chk(16'(compare_match_flag), 16'h0000);
		pul(2'h0, 2'h0, 2'h0, 2'h1, 1'b0, 4'hC);
		mt(v);
		chk(16'({compare_match_flag, wave_output}), 16'({3'h3, nw(1'b0, 2'h0)}));
		chk(16'({pin_oe, pin_out}), 16'h000F);
		pul(2'h0, 2'h0, 2'h1, 2'h0, 1'b0, 4'hC);
		chk(16'(compare_match_flag), 16'h0000);
		$display("test block and action done");
		@(posedge ref_clk);
		waveform_select <= 4'hF;
		pul(2'h3, 2'h0, 2'h0, 2'h0, 1'b0, 4'hC);
		chk(16'(wave_output), 16'h0002);
		wr(16'hFFFF);
		chk(rd_word, 16'hFFFF);
		chk(top_from_a, v);
		@(posedge ref_clk);
		at_top <= 1'b1;
		mt(16'h0000);
		chk(top_from_a, 16'hFFFF);
		$display("test buffer done");
		@(posedge ref_clk);
		{waveform_select, compare_irq_enable_in, at_top} <= {4'hC, 2'h2, 1'b0};
		{port_value, pin_direction_bit} <= 4'h1;
		pul(2'h0, 2'h0, 2'h0, 2'h3, 1'b0, 4'h1);
		chk(16'(compare_irq), 16'h0002);
		pul(2'h3, 2'h0, 2'h0, 2'h0, 1'b0, 4'h1);
		chk(16'(wave_output), 16'h0003);
		chk(16'({pin_oe, pin_out}), 16'h0005);
		pul(2'h0, 2'h2, 2'h0, 2'h0, 1'b0, 4'h1);
		chk(16'({compare_irq, compare_match_flag}), 16'h0000);
		@(posedge ref_clk);
		waveform_select <= 4'h4;
		rs = xs(rs);
		v = rs[15:0];
		wr(v);
		chk(top_from_a, v);
		chk(rd_word, v);
		$display("test clear on match and pins done");
		conclude();
	end
endmodule : output_compare_unit_16bit_bench
